//--- hw/pbw_consts.svh
// Offsets, field positions, reset values and storage layout of the bandwidth configuration block.
`ifndef PBW_CONSTS_SVH
`define PBW_CONSTS_SVH

// Byte offsets inside one feature page.
`define PBW_OFF_SELECTOR       12'h100
`define PBW_OFF_WINDOW         12'h220
`define PBW_OFF_STRIDE         12'h500
`define PBW_OFF_NARROW_MAP     12'h600

// Selector fields.
`define PBW_SEL_PART_MSB       15
`define PBW_SEL_INTERNAL_BIT   16
`define PBW_SEL_PICK_MSB       27
`define PBW_SEL_PICK_LSB       24
`define PBW_SEL_RESET          32'h0000_0000

// Stride control fields.
`define PBW_STRIDE_EN_BIT      31
`define PBW_STRIDE_MSB         15
`define PBW_STRIDE_FIELD_W     16

// Window width fields.
`define PBW_WIN_INT_MSB        23
`define PBW_WIN_INT_LSB        8
`define PBW_WIN_FRAC_MSB       7
`define PBW_WIN_W              24

// Stored word per partition: enable, stride, window.
`define PBW_WORD_W             41
`define PBW_WORD_EN_BIT        40
`define PBW_WORD_STRIDE_MSB    39
`define PBW_WORD_STRIDE_LSB    24
`define PBW_WORD_WIN_MSB       23
`define PBW_WORD_STRIDE_MASK   41'h1_ffff_00_0000
`define PBW_WORD_WIN_MASK      41'h0_0000_ff_ffff
`define PBW_WORD_ALL_MASK      41'h1_ffff_ff_ffff

`endif

//--- hw/pbw_pkg.sv
// Types shared by the bandwidth configuration block.
package pbw_pkg;

  typedef enum logic [1:0] {
    PBW_IDLE,
    PBW_LOOKUP,
    PBW_ANSWER
  } pbw_state_t;

  typedef enum logic [1:0] {
    PBW_ERR_NONE,
    PBW_ERR_UNEXPECTED_INTERNAL,
    PBW_ERR_INTERNAL_RANGE
  } pbw_err_t;

endpackage

//--- hw/pbw_cfg_mem.sv
// Per-partition settings store with masked write and two registered read ports.
`timescale 1ns/10ps
module pbw_cfg_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 41
) (
  // Clock
  input  wire logic              mclk,
  // Masked write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_mask,
  input  wire logic [DATA_W-1:0] wr_data,
  // Register-side read port
  input  wire logic [ADDR_W-1:0] a_addr,
  output logic      [DATA_W-1:0] a_data,
  // Regulator-side read port
  input  wire logic [ADDR_W-1:0] b_addr,
  output logic      [DATA_W-1:0] b_data
);

  logic [DATA_W-1:0] mem [1<<ADDR_W];

  // Contents carry no reset; a separate valid bit per entry hides stale words.
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge mclk) begin
    a_data <= mem[a_addr];
    b_data <= mem[b_addr];
  end

endmodule

//--- hw/pbw_bw_config.sv
// Partition selector, proportional stride and window width registers for both security pages.
//
// Notes on behaviour
// - Stride enable bit 31 turns proportional stride regulation on for the selected partition.
// - Stride field bits 15..0 hold stride minus one; larger means less bandwidth.
// - Implemented stride bits equal the reported bandwidth allocation width.
// - A partition's stride is its relative cost against other competing partitions.
// - Stride needs bandwidth and stride support; window needs bandwidth; absent reads zero.
// - Selector exists only with some partitioning or narrowing; otherwise zero and ignored.
// - Without window write capability the window register is read-only and hardware set.
// - With window write capability each partition holds its own writable window width.
// - Window holds integer microseconds 23..8, fraction 7..0; bits 31..24 read zero.
// - Secure and non-secure pages own separate instances controlling their own partitions.
// - Selector bits 15..0 name the partition later configuration accesses reach.
// - Configuration storage is indexed by selected partition and the page's security state.
// - Selector bits 27..24 pick resource instance when widened and supported, else zero.
// - Selector internal bit 16 reads zero, ignores writes, without narrowing.
// - Internal flag clear: selection serves only the narrowing map register.
// - Internal flag set: selection serves every configuration register but the map.
// - Map access with internal flag set records an unexpected-internal error.
// - Other configuration access with internal flag clear records an internal range error.
// - On either error reads return zero here and writes change nothing.
`timescale 1ns/10ps
`include "pbw_consts.svh"
module pbw_bw_config #(
  parameter int   PART_BITS                      = 6,
  parameter int   BANDWIDTH_ALLOC_WIDTH                         = 16,
  parameter logic BANDWIDTH_PARTITIONING_PRESENT = 1'b1,
  parameter logic STRIDE_CONTROL_PRESENT         = 1'b1,
  parameter logic OTHER_PARTITIONING_PRESENT     = 1'b0,
  parameter logic NARROWING_PRESENT              = 1'b1,
  parameter logic RESOURCE_SELECT_PRESENT        = 1'b1,
  parameter logic WIDENED_FEATURES_FLAG          = 1'b1,
  parameter logic WINDOW_WRITABLE_CAP            = 1'b1
) (
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // Feature page access port
  input  wire logic           reg_req,
  input  wire logic           reg_wr,
  input  wire logic           reg_security_state,
  input  wire logic [11:0]    reg_addr,
  input  wire logic [31:0]    reg_wdata,
  output logic                reg_ready,
  output logic                reg_ack,
  output logic      [31:0]    reg_rdata,
  // Hardware window width when software cannot set it
  input  wire logic [23:0]    hw_window_us,
  // Resource instance picks for identification logic
  output logic      [3:0]     pick_secure,
  output logic      [3:0]     pick_nonsecure,
  // Error status report
  output logic                err_pulse,
  output pbw_pkg::pbw_err_t   err_code,
  output logic                err_security_state,
  // Regulator lookup port
  input  wire logic           rgl_security_state,
  input  wire logic [PART_BITS-1:0] rgl_partition,
  output logic                rgl_stride_en,
  output logic      [16:0]    rgl_cost,
  output logic      [23:0]    rgl_window_us
);
  import pbw_pkg::*;

  localparam int IDX_W   = PART_BITS + 1;
  localparam int ENTRIES = 1 << IDX_W;
  localparam logic SEL_PRESENT = BANDWIDTH_PARTITIONING_PRESENT | OTHER_PARTITIONING_PRESENT |
                                 NARROWING_PRESENT;
  localparam logic STRIDE_PRESENT = BANDWIDTH_PARTITIONING_PRESENT & STRIDE_CONTROL_PRESENT;
  localparam logic WINDOW_PRESENT = BANDWIDTH_PARTITIONING_PRESENT;
  localparam logic PICK_ON = WIDENED_FEATURES_FLAG & RESOURCE_SELECT_PRESENT;
  localparam logic [15:0] STRIDE_MASK = 16'((33'd1 << BANDWIDTH_ALLOC_WIDTH) - 33'd1);
  localparam logic [31:0] SEL_WMASK = {4'h0, {4{PICK_ON}}, 7'h00, NARROWING_PRESENT, 16'hffff};

  // State
  pbw_state_t              state_reg;
  pbw_state_t              state_next;
  logic [31:0]             sel_reg [2];
  logic [ENTRIES-1:0]      valid_reg;
  logic [31:0]             rdata_reg;
  logic [31:0]             rdata_next;
  logic                    rd_sel_q;
  logic                    rd_win_q;
  logic                    rd_str_q;
  logic                    rd_valid_q;
  logic [31:0]             sel_val_q;
  logic                    err_pulse_reg;
  pbw_err_t                err_code_reg;
  logic                    err_sec_reg;
  logic                    rgl_valid_q;
  logic                    rgl_en_reg;
  logic [16:0]             rgl_cost_reg;
  logic [23:0]             rgl_win_reg;
  logic [`PBW_WORD_W-1:0]  a_word;
  logic [`PBW_WORD_W-1:0]  b_word;

  // Decode
  wire        sec          = reg_security_state;
  wire [31:0] sel_cur      = sel_reg[sec];
  wire [15:0] sel_part     = sel_cur[`PBW_SEL_PART_MSB:0];
  wire        sel_internal = sel_cur[`PBW_SEL_INTERNAL_BIT];
  wire        part_in_range = 32'(sel_part) < (32'd1 << PART_BITS);
  wire [IDX_W-1:0] idx    = {sec, sel_part[PART_BITS-1:0]};
  wire        take         = reg_req && (state_reg == PBW_IDLE);
  wire        hit_sel      = SEL_PRESENT && (reg_addr == `PBW_OFF_SELECTOR);
  wire        hit_win      = WINDOW_PRESENT && (reg_addr == `PBW_OFF_WINDOW);
  wire        hit_str      = STRIDE_PRESENT && (reg_addr == `PBW_OFF_STRIDE);
  wire        hit_map      = NARROWING_PRESENT && (reg_addr == `PBW_OFF_NARROW_MAP);
  // The map register itself lives elsewhere; only its selector check is made here.
  wire        err_unexp    = take && hit_map && sel_internal;
  wire        err_range    = take && (hit_win || hit_str) && NARROWING_PRESENT &&
                             !sel_internal;
  wire        cfg_ok       = !err_range && part_in_range;
  wire        entry_valid  = valid_reg[idx];

  // Selector write
  wire        sel_we       = take && reg_wr && hit_sel;
  wire [31:0] sel_wr_value = reg_wdata & SEL_WMASK;

  // Settings write
  wire        win_we       = hit_win && WINDOW_WRITABLE_CAP;
  wire        mem_we       = take && reg_wr && cfg_ok && (hit_str || win_we);
  wire [`PBW_WORD_W-1:0] field_mask = hit_str ? `PBW_WORD_STRIDE_MASK : `PBW_WORD_WIN_MASK;
  wire [`PBW_WORD_W-1:0] word_in = {reg_wdata[`PBW_STRIDE_EN_BIT],
                                    reg_wdata[`PBW_STRIDE_MSB:0] & STRIDE_MASK,
                                    reg_wdata[`PBW_WIN_INT_MSB:0]};
  // A first write to an entry clears the other field so nothing stale ever shows.
  wire [`PBW_WORD_W-1:0] wr_mask = entry_valid ? field_mask : `PBW_WORD_ALL_MASK;
  wire [`PBW_WORD_W-1:0] wr_data = word_in & field_mask;

  // Reads that are absent, out of range or in error return zero.
  wire        rd_ok        = take && !reg_wr && cfg_ok;

  pbw_cfg_mem #(
    .ADDR_W (IDX_W),
    .DATA_W (`PBW_WORD_W)
  ) u_store (
    .mclk    (mclk),
    .wr_en   (mem_we),
    .wr_addr (idx),
    .wr_mask (wr_mask),
    .wr_data (wr_data),
    .a_addr  (idx),
    .a_data  (a_word),
    .b_addr  ({rgl_security_state, rgl_partition}),
    .b_data  (b_word)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sel
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sel_reg[g] <= `PBW_SEL_RESET;
        end else if (sel_we && (sec == 1'(g))) begin
          sel_reg[g] <= sel_wr_value;
        end
      end
    end
    for (g = 0; g < ENTRIES; g++) begin : g_valid
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          valid_reg[g] <= 1'b0;
        end else if (mem_we && (idx == IDX_W'(g))) begin
          valid_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  assign pick_secure    = sel_reg[0][`PBW_SEL_PICK_MSB:`PBW_SEL_PICK_LSB];
  assign pick_nonsecure = sel_reg[1][`PBW_SEL_PICK_MSB:`PBW_SEL_PICK_LSB];

  // Access sequencer
  always_comb begin
    case (state_reg)
      PBW_IDLE:   state_next = reg_req ? PBW_LOOKUP : PBW_IDLE;
      PBW_LOOKUP: state_next = PBW_ANSWER;
      PBW_ANSWER: state_next = PBW_IDLE;
      default:    state_next = PBW_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= PBW_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_sel_q   <= 1'b0;
      rd_win_q   <= 1'b0;
      rd_str_q   <= 1'b0;
      rd_valid_q <= 1'b0;
      sel_val_q  <= 32'h0000_0000;
    end else if (take) begin
      rd_sel_q   <= !reg_wr && hit_sel;
      rd_win_q   <= rd_ok && hit_win;
      rd_str_q   <= rd_ok && hit_str;
      rd_valid_q <= entry_valid;
      sel_val_q  <= sel_cur;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_sel_q) begin
      rdata_next = sel_val_q;
    end else if (rd_str_q && rd_valid_q) begin
      rdata_next = {a_word[`PBW_WORD_EN_BIT], 15'h0000,
                    a_word[`PBW_WORD_STRIDE_MSB:`PBW_WORD_STRIDE_LSB]};
    end else if (rd_win_q && !WINDOW_WRITABLE_CAP) begin
      rdata_next = {8'h00, hw_window_us};
    end else if (rd_win_q && rd_valid_q) begin
      rdata_next = {8'h00, a_word[`PBW_WORD_WIN_MSB:0]};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (state_reg == PBW_LOOKUP) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_ready = (state_reg == PBW_IDLE);
  assign reg_ack   = (state_reg == PBW_ANSWER);
  assign reg_rdata = rdata_reg;

  // Error report
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_pulse_reg <= 1'b0;
      err_code_reg  <= PBW_ERR_NONE;
      err_sec_reg   <= 1'b0;
    end else begin
      err_pulse_reg <= err_unexp || err_range;
      if (err_unexp) begin
        err_code_reg <= PBW_ERR_UNEXPECTED_INTERNAL;
        err_sec_reg  <= sec;
      end else if (err_range) begin
        err_code_reg <= PBW_ERR_INTERNAL_RANGE;
        err_sec_reg  <= sec;
      end
    end
  end

  assign err_pulse          = err_pulse_reg;
  assign err_code           = err_code_reg;
  assign err_security_state = err_sec_reg;

  // Regulator lookup: cost is stride plus one so arbiters can weigh partitions directly.
  wire [15:0] b_stride = b_word[`PBW_WORD_STRIDE_MSB:`PBW_WORD_STRIDE_LSB];
  wire        b_en     = rgl_valid_q && b_word[`PBW_WORD_EN_BIT];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rgl_valid_q  <= 1'b0;
      rgl_en_reg   <= 1'b0;
      rgl_cost_reg <= 17'h0_0000;
      rgl_win_reg  <= 24'h00_0000;
    end else begin
      rgl_valid_q  <= valid_reg[{rgl_security_state, rgl_partition}];
      rgl_en_reg   <= b_en;
      rgl_cost_reg <= b_en ? 17'(b_stride) + 17'h0_0001 : 17'h0_0000;
      if (!WINDOW_WRITABLE_CAP) begin
        rgl_win_reg <= hw_window_us;
      end else begin
        rgl_win_reg <= rgl_valid_q ? b_word[`PBW_WORD_WIN_MSB:0] : 24'h00_0000;
      end
    end
  end

  assign rgl_stride_en = rgl_en_reg;
  assign rgl_cost      = rgl_cost_reg;
  assign rgl_window_us = rgl_win_reg;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_take;
    reg_req && reg_ready;
  endsequence

  sequence s_answer;
    !reg_ready ##1 reg_ack;
  endsequence

  a_answer_timing: assert property (s_take |=> s_answer)
    else $error("Answer did not come two cycles after the request.");

  a_sel_takes_part: assert property ((take && reg_wr && hit_sel) |=>
    sel_reg[$past(sec)][15:0] == $past(reg_wdata[15:0]))
    else $error("Selector did not take the written partition.");

  a_sel_page_apart: assert property (sel_we |=>
    ($past(sec) ? $stable(sel_reg[0]) : $stable(sel_reg[1])))
    else $error("Selector write changed the other page.");

  a_internal_raz: assert property (!NARROWING_PRESENT |->
    !sel_reg[0][`PBW_SEL_INTERNAL_BIT] && !sel_reg[1][`PBW_SEL_INTERNAL_BIT])
    else $error("Internal flag set without narrowing.");

  a_pick_reserved: assert property (!PICK_ON |-> (pick_secure == 4'h0) &&
    (pick_nonsecure == 4'h0))
    else $error("Resource pick set while reserved.");

  a_sel_absent: assert property (!SEL_PRESENT |-> (sel_reg[0] == 32'h0) &&
    (sel_reg[1] == 32'h0))
    else $error("Absent selector holds a value.");

  a_unexp_error: assert property ((take && hit_map && sel_internal) |=>
    err_pulse && (err_code == PBW_ERR_UNEXPECTED_INTERNAL))
    else $error("Unexpected internal error not reported.");

  a_range_error: assert property ((take && NARROWING_PRESENT && (hit_str || hit_win) &&
    !sel_internal) |=> err_pulse && (err_code == PBW_ERR_INTERNAL_RANGE))
    else $error("Internal range error not reported.");

  a_error_no_write: assert property ((err_range || err_unexp) |-> !mem_we)
    else $error("Settings written during a narrowing error.");

  a_window_ro: assert property (!WINDOW_WRITABLE_CAP && take && hit_win |-> !mem_we)
    else $error("Read-only window width was written.");

  a_window_resv: assert property ((take && !reg_wr && hit_win) |-> ##2
    (reg_ack && (reg_rdata[31:24] == 8'h00)))
    else $error("Window reserved bits not zero.");

  a_stride_width: assert property ((take && !reg_wr && hit_str) |-> ##2
    (reg_rdata[30:16] == 15'h0000) && ((reg_rdata[15:0] & ~STRIDE_MASK) == 16'h0000))
    else $error("Stride readback outside implemented bits.");

  a_absent_zero: assert property ((take && !reg_wr && (reg_addr == `PBW_OFF_STRIDE) &&
    !STRIDE_PRESENT) |-> ##2 (reg_rdata == 32'h0))
    else $error("Absent stride register did not read zero.");

  // The cost must follow the stored stride one for one, so a larger stride never costs less.
  a_cost_order: assert property (rgl_stride_en |->
    (rgl_cost == 17'($past(b_stride)) + 17'h0_0001))
    else $error("Enabled partition cost does not follow its stride.");

endmodule

//--- sim/pbw_bw_config_bench.sv
// Self-checking bench for the partition bandwidth configuration block.
`timescale 1ns/10ps
`include "pbw_consts.svh"
module pbw_bw_config_bench;
  import pbw_pkg::*;
  localparam int PB = 3;
  // Stimulus
  logic          mclk      = 1'b0;
  logic          rst       = 1'b1;
  logic          reg_req   = 1'b0;
  logic          reg_wr    = 1'b0;
  logic          reg_ss    = 1'b0;
  logic [11:0]   reg_addr  = 12'h000;
  logic [31:0]   reg_wdata = 32'h0000_0000;
  logic [23:0]   hw_win    = 24'h00_0000;
  logic          rgl_ss    = 1'b0;
  logic [PB-1:0] rgl_part  = '0;
  // Observed outputs
  logic          rdy;
  logic          ack;
  logic          ack2;
  logic [31:0]   rdata;
  logic [31:0]   rdata2;
  logic [3:0]    pick_s;
  logic [3:0]    pick_ns;
  logic          err_pulse;
  logic          err2;
  pbw_err_t      err_code;
  logic          err_ss;
  logic          rgl_en;
  logic [16:0]   rgl_cost;
  logic [23:0]   rgl_win;
  logic [23:0]   rgl_win2;
  logic          rgl_en2;
  // Bookkeeping and reference model
  int            err_count = 0;
  int            tests_run = 0;
  int            cycles    = 0;
  logic [32:0]   q1[$];
  logic [32:0]   q2[$];
  logic [2:0]    qe[$];
  logic [32:0]   n1;
  logic [32:0]   n2;
  logic [2:0]    ne;
  logic [31:0]   sel[2]     = '{default: '0};
  logic [31:0]   sel2[2]    = '{default: '0};
  logic [31:0]   stm[2][8]  = '{default: '0};
  logic [23:0]   wim[2][8]  = '{default: '0};
  logic [31:0]   rnd        = 32'h29ab;

  pbw_bw_config #(.PART_BITS(PB)) pbw_bw_config_inst (
    .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr), .reg_security_state(reg_ss),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(rdy), .reg_ack(ack),
    .reg_rdata(rdata), .hw_window_us(hw_win), .pick_secure(pick_s), .pick_nonsecure(pick_ns),
    .err_pulse(err_pulse), .err_code(err_code), .err_security_state(err_ss),
    .rgl_security_state(rgl_ss), .rgl_partition(rgl_part), .rgl_stride_en(rgl_en),
    .rgl_cost(rgl_cost), .rgl_window_us(rgl_win));

  // A lean variant: no stride, no narrowing, no instance pick, window fixed by hardware.
  pbw_bw_config #(.PART_BITS(PB), .STRIDE_CONTROL_PRESENT(1'b0), .NARROWING_PRESENT(1'b0),
    .RESOURCE_SELECT_PRESENT(1'b0), .WINDOW_WRITABLE_CAP(1'b0)) pbw_bw_config_inst2 (
    .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr), .reg_security_state(reg_ss),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(), .reg_ack(ack2),
    .reg_rdata(rdata2), .hw_window_us(hw_win), .pick_secure(), .pick_nonsecure(),
    .err_pulse(err2), .err_code(), .err_security_state(), .rgl_security_state(rgl_ss),
    .rgl_partition(rgl_part), .rgl_stride_en(rgl_en2), .rgl_cost(), .rgl_window_us(rgl_win2));

  always #20 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic close_out();
    if (q1.size() != 0 || q2.size() != 0 || qe.size() != 0) begin
      err_count++;
    end
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One access; the model predicts both variants, the monitor compares at the answer.
  task automatic acc(input logic wr, input logic ss, input logic [11:0] a, input logic [31:0] d);
    logic [15:0] p;
    logic [31:0] e;
    logic [31:0] e2;
    e = 32'h0;
    e2 = 32'h0;
    if (a == `PBW_OFF_SELECTOR) begin
      if (wr) sel[ss] = d & 32'h0f01_ffff;
      if (wr) sel2[ss] = d & 32'h0000_ffff;
      e = sel[ss];
      e2 = sel2[ss];
    end else if (a == `PBW_OFF_NARROW_MAP) begin
      if (sel[ss][16]) qe.push_back({ss, PBW_ERR_UNEXPECTED_INTERNAL});
    end else if (a == `PBW_OFF_STRIDE || a == `PBW_OFF_WINDOW) begin
      p = sel[ss][15:0];
      if (!sel[ss][16]) begin
        qe.push_back({ss, PBW_ERR_INTERNAL_RANGE});
      end else if (p < 16'd8) begin
        if (wr && a == `PBW_OFF_STRIDE) stm[ss][p] = d & 32'h8000_ffff;
        if (wr && a == `PBW_OFF_WINDOW) wim[ss][p] = d[23:0];
        e = (a == `PBW_OFF_STRIDE) ? stm[ss][p] : {8'h00, wim[ss][p]};
      end
      // Partitions beyond storage read zero even where hardware fixes the window.
      if (a == `PBW_OFF_WINDOW && sel2[ss][15:0] < 16'd8) e2 = {8'h00, hw_win};
    end
    q1.push_back({!wr, e});
    q2.push_back({!wr, e2});
    reg_req <= 1'b1;
    reg_wr <= wr;
    reg_ss <= ss;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    check({30'h0, rdy, ack}, 32'h2);
    reg_req <= 1'b0;
    @(posedge mclk);
    check({30'h0, rdy, ack}, 32'h0);
    @(posedge mclk);
    check({30'h0, rdy, ack}, 32'h1);
  endtask

  task automatic look(input logic ss, input logic [PB-1:0] p);
    logic [16:0] c;
    rgl_ss <= ss;
    rgl_part <= p;
    repeat (3) @(posedge mclk);
    c = stm[ss][p][31] ? {1'b0, stm[ss][p][15:0]} + 17'd1 : 17'h0;
    check({31'h0, rgl_en}, {31'h0, stm[ss][p][31]});
    check({15'h0, rgl_cost}, {15'h0, c});
    check({8'h0, rgl_win}, {8'h0, wim[ss][p]});
    check({8'h0, rgl_win2}, {8'h0, hw_win});
    check({31'h0, rgl_en2}, 32'h0);
    check({24'h0, pick_s, pick_ns}, {24'h0, sel[0][27:24], sel[1][27:24]});
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (ack === 1'b1 && q1.size() > 0) begin
      n1 = q1.pop_front();
      if (n1[32]) check(rdata, n1[31:0]);
    end
    if (ack2 === 1'b1 && q2.size() > 0) begin
      n2 = q2.pop_front();
      if (n2[32]) check(rdata2, n2[31:0]);
    end
    if (err_pulse === 1'b1) begin
      ne = (qe.size() > 0) ? qe.pop_front() : 3'b111;
      check({29'h0, err_ss, err_code}, {29'h0, ne});
    end
    if (err2 !== 1'b0) check({31'h0, err2}, 32'h0);
    if (cycles > 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    rnd = lfsr(rnd);
    hw_win <= rnd[23:0];
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // Fresh selector reads zero, so a stride access first is a range error.
    acc(1'b0, 1'b0, `PBW_OFF_SELECTOR, 32'h0);
    acc(1'b0, 1'b0, `PBW_OFF_STRIDE, 32'h0);
    acc(1'b1, 1'b0, `PBW_OFF_NARROW_MAP, 32'h0);
    // Random settings for every partition of both pages, two beyond storage.
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 10; p++) begin
        rnd = lfsr(rnd);
        acc(1'b1, s[0], `PBW_OFF_SELECTOR, {rnd[31:17], 1'b1, p[15:0]});
        rnd = lfsr(rnd);
        acc(1'b1, s[0], `PBW_OFF_STRIDE, rnd);
        rnd = lfsr(rnd);
        acc(1'b1, s[0], `PBW_OFF_WINDOW, rnd);
        acc(1'b0, s[0], `PBW_OFF_SELECTOR, 32'h0);
      end
    end
    // Read back afterwards, so crosstalk between pages or partitions shows.
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 10; p++) begin
        rnd = lfsr(rnd);
        acc(1'b1, s[0], `PBW_OFF_SELECTOR, {rnd[31:17], 1'b1, p[15:0]});
        acc(1'b0, s[0], `PBW_OFF_STRIDE, 32'h0);
        acc(1'b0, s[0], `PBW_OFF_WINDOW, 32'h0);
        if (p < 8) look(s[0], p[PB-1:0]);
      end
    end
    // Writes with the internal flag clear must change nothing.
    acc(1'b1, 1'b0, `PBW_OFF_SELECTOR, 32'h0000_0003);
    acc(1'b1, 1'b0, `PBW_OFF_STRIDE, 32'h8000_1234);
    acc(1'b1, 1'b0, `PBW_OFF_WINDOW, 32'h00ab_cdef);
    acc(1'b1, 1'b0, `PBW_OFF_SELECTOR, 32'h0501_0003);
    acc(1'b0, 1'b0, `PBW_OFF_STRIDE, 32'h0);
    acc(1'b0, 1'b0, `PBW_OFF_WINDOW, 32'h0);
    acc(1'b1, 1'b0, `PBW_OFF_NARROW_MAP, 32'h0);
    acc(1'b0, 1'b0, `PBW_OFF_NARROW_MAP, 32'h0);
    look(1'b0, 3'd3);
    // Largest stride gives the top cost; unmapped offsets read zero.
    acc(1'b1, 1'b0, `PBW_OFF_STRIDE, 32'hffff_ffff);
    acc(1'b1, 1'b1, 12'h7fc, rnd);
    acc(1'b0, 1'b1, 12'h7fc, 32'h0);
    look(1'b0, 3'd3);
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule
